// *** rtl/sto_supervisor.sv ***
`timescale 1ns/1ps

module sto_supervisor (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Safety and drive pins
	input  wire logic        safety_disable_input,
	input  wire logic        thermistor_trip_output,
	input  wire logic        thermistor_present,
	input  wire logic        digital_reset_input,
	input  wire logic        local_operator_panel_reset,
	output logic             field_enable,
	output logic             brake_engage,
	output logic             torque_off_status,
	output logic             torque_off_alarm_code,
	output logic             torque_off_warning_code,
	output logic             dangerous_failure_alarm_code,
	output logic             irq,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	import sto_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Known register offset
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == MODE_OFS) || (a == STATUS_OFS) || (a == CONTROL_OFS)
			|| (a == IRQ_STATUS_OFS) || (a == IRQ_CLEAR_OFS) || (a == IRQ_ENABLE_OFS);
	endfunction : is_mapped

	// Mode code allowed with or without the thermistor module
	function automatic logic mode_allowed(input logic [3:0] m, input logic present);
		mode_allowed = (m == MODE_STO_ALARM) || (m == MODE_STO_WARNING)
			|| (present && (m >= MODE_THERMISTOR_ONLY_ALARM) && (m <= MODE_COMBINED_WARNING_ALARM));
	endfunction : mode_allowed

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic                 safe_meta_q, safe_sync_q;
	logic                 therm_meta_q, therm_sync_q;
	logic                 dig_meta_q, dig_sync_q, dig_prev_q;
	logic                 key_meta_q, key_sync_q, key_prev_q;
	sto_state_t           state_q, state_d;
	logic [3:0]           mode_q;
	logic                 alarm68_q, alarm68_d;
	logic                 warn68_q, warn68_d;
	logic                 alarm72_q, alarm72_d;
	logic [EVT_WIDTH-1:0] irq_status_q, irq_enable_q;
	logic                 aw_have_q, w_have_q;
	logic [7:0]           aw_addr_q;
	logic [31:0]          w_data_q;
	logic [3:0]           w_strb_q;
	logic                 bvalid_q, rvalid_q;
	logic [1:0]           bresp_q, rresp_q;
	logic [31:0]          rdata_q;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Two flops per pin except thermistor_present, plus an edge flop on both reset pins; first flop read only by second
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			safe_meta_q  <= 1'b0;
			safe_sync_q  <= 1'b0;
			therm_meta_q <= 1'b1;
			therm_sync_q <= 1'b1;
			dig_meta_q   <= 1'b0;
			dig_sync_q   <= 1'b0;
			dig_prev_q   <= 1'b0;
			key_meta_q   <= 1'b0;
			key_sync_q   <= 1'b0;
			key_prev_q   <= 1'b0;
		end else begin
			safe_meta_q  <= safety_disable_input;
			safe_sync_q  <= safe_meta_q;
			therm_meta_q <= thermistor_trip_output;
			therm_sync_q <= therm_meta_q;
			dig_meta_q   <= digital_reset_input;
			dig_sync_q   <= dig_meta_q;
			dig_prev_q   <= dig_sync_q;
			key_meta_q   <= local_operator_panel_reset;
			key_sync_q   <= key_meta_q;
			key_prev_q   <= key_sync_q;
		end
	end

	// ----------------------------------------
	// Bus write decode
	// ----------------------------------------
	// Write fires once both address and data are held
	wire        wr_fire      = aw_have_q && w_have_q && !bvalid_q;
	wire        wr_ok        = wr_fire && is_mapped(aw_addr_q);
	wire        wr_mode      = wr_ok && (aw_addr_q == MODE_OFS) && w_strb_q[0];
	wire        wr_control   = wr_ok && (aw_addr_q == CONTROL_OFS) && w_strb_q[0];
	wire        wr_clear     = wr_ok && (aw_addr_q == IRQ_CLEAR_OFS) && w_strb_q[0];
	wire        wr_enable    = wr_ok && (aw_addr_q == IRQ_ENABLE_OFS) && w_strb_q[0];
	wire [3:0]  new_mode     = w_data_q[3:0];
	wire        rd_fire      = s_axi_arvalid && !rvalid_q;

	// ----------------------------------------
	// Restart and trigger decode
	// ----------------------------------------
	// Any of the three reset sources, one-cycle pulse
	wire fieldbus_reset = wr_control && w_data_q[CONTROL_RESET_BIT];
	wire reset_pulse    = fieldbus_reset || (dig_sync_q && !dig_prev_q) || (key_sync_q && !key_prev_q);
	wire stop_request   = !safe_sync_q;
	wire therm_tripped  = !therm_sync_q;
	wire auto_restart   = (mode_q == MODE_STO_WARNING)
		|| (mode_q == MODE_COMBINED_WARNING) || (mode_q == MODE_COMBINED_ALARM_WARNING);
	wire plain_mode     = (mode_q == MODE_STO_ALARM) || (mode_q == MODE_STO_WARNING);
	wire therm_only     = (mode_q == MODE_THERMISTOR_ONLY_ALARM) || (mode_q == MODE_THERMISTOR_ONLY_WARNING);
	wire danger_cause   = (plain_mode && therm_tripped)
		|| (therm_only && !therm_tripped);
	wire alarm_kind     = (mode_q == MODE_STO_ALARM) || (mode_q == MODE_COMBINED_ALARM)
		|| (mode_q == MODE_COMBINED_WARNING_ALARM) || (mode_q == MODE_THERMISTOR_ONLY_ALARM);
	wire warn_kind      = auto_restart || (mode_q == MODE_THERMISTOR_ONLY_WARNING);

	// ----------------------------------------
	// Supervisor state machine
	// ----------------------------------------
	always_comb begin
		state_d   = state_q;
		alarm68_d = alarm68_q;
		warn68_d  = warn68_q;
		alarm72_d = alarm72_q;
		unique case (state_q)
			ST_RUN: begin
				if (stop_request) begin
					// Coast at once; cause picks the indication
					alarm72_d = danger_cause;
					alarm68_d = !danger_cause && alarm_kind;
					warn68_d  = !danger_cause && warn_kind;
					state_d   = danger_cause ? ST_DANGER : ST_OFF_LOW;
				end
			end
			ST_OFF_LOW: begin
				// Reset ignored while input low
				if (!stop_request) begin
					state_d = auto_restart ? ST_RUN : ST_OFF_WAIT;
				end
			end
			ST_OFF_WAIT: begin
				// Input high alone keeps coasting; reset resumes
				if (stop_request) begin
					state_d = ST_OFF_LOW;
				end else if (reset_pulse) begin
					state_d = ST_RUN;
				end
			end
			ST_DANGER: begin
				// Never automatic; needs input high and a reset
				if (!stop_request && reset_pulse) begin
					state_d = ST_RUN;
				end
			end
		endcase
		if (state_d == ST_RUN) begin
			alarm68_d = 1'b0;
			warn68_d  = 1'b0;
			alarm72_d = 1'b0;
		end
	end

	// State and indication registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q   <= ST_OFF_LOW;
			alarm68_q <= 1'b0;
			warn68_q  <= 1'b0;
			alarm72_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			alarm68_q <= alarm68_d;
			warn68_q  <= warn68_d;
			alarm72_q <= alarm72_d;
		end
	end

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	// Unavailable selections are dropped, old mode kept
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mode_q <= MODE_RESET;
		end else if (wr_mode && mode_allowed(new_mode, thermistor_present)) begin
			mode_q <= new_mode;
		end
	end

	// ----------------------------------------
	// Drive outputs
	// ----------------------------------------
	// Field needs both the run state and a live input
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			field_enable <= 1'b0;
			brake_engage <= 1'b1;
			torque_off_status <= 1'b1;
		end else begin
			field_enable      <= (state_d == ST_RUN) && !stop_request;
			brake_engage      <= (state_d != ST_RUN);
			torque_off_status <= (state_d != ST_RUN);
		end
	end

	assign torque_off_alarm_code        = alarm68_q;
	assign torque_off_warning_code      = warn68_q;
	assign dangerous_failure_alarm_code = alarm72_q;

	// ----------------------------------------
	// Interrupt status, enable and clear
	// ----------------------------------------
	wire [EVT_WIDTH-1:0] evt_set = {
		(state_q != ST_RUN) && (state_d == ST_RUN),
		(state_q != ST_DANGER) && (state_d == ST_DANGER),
		(state_q == ST_RUN) && (state_d != ST_RUN)
	};
	wire [EVT_WIDTH-1:0] evt_clr = wr_clear ? w_data_q[EVT_WIDTH-1:0] : EVT_RESET;

	// Set wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_status_q <= EVT_RESET;
			irq_enable_q <= EVT_RESET;
		end else begin
			irq_status_q <= (irq_status_q & ~evt_clr) | evt_set;
			if (wr_enable) begin
				irq_enable_q <= w_data_q[EVT_WIDTH-1:0];
			end
		end
	end

	assign irq = |(irq_status_q & irq_enable_q);

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready  = !w_have_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// Hold address and data, answer when both present
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? 2'h0 : 2'h2;
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// Status word: state, indications, pins
	wire [31:0] status_word = {24'h00_0000, thermistor_present, therm_tripped, safe_sync_q,
		alarm72_q, warn68_q, alarm68_q, state_q};
	wire [31:0] rd_word =
		(s_axi_araddr == MODE_OFS)       ? {28'h000_0000, mode_q} :
		(s_axi_araddr == STATUS_OFS)     ? status_word :
		(s_axi_araddr == IRQ_STATUS_OFS) ? {29'h0000_0000, irq_status_q} :
		(s_axi_araddr == IRQ_ENABLE_OFS) ? {29'h0000_0000, irq_enable_q} :
		32'h0000_0000;

	// One-cycle read answer; write-only words read zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= 2'h0;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule : sto_supervisor

// *** pkg/sto_pkg.sv ***
package sto_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] MODE_OFS       = 8'h00;
	localparam logic [7:0] STATUS_OFS     = 8'h04;
	localparam logic [7:0] CONTROL_OFS    = 8'h08;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h0C;
	localparam logic [7:0] IRQ_CLEAR_OFS  = 8'h10;
	localparam logic [7:0] IRQ_ENABLE_OFS = 8'h14;

	// ----------------------------------------
	// Mode selection codes
	// ----------------------------------------
	localparam logic [3:0] MODE_STO_ALARM                  = 4'h1;
	localparam logic [3:0] MODE_STO_WARNING                = 4'h3;
	localparam logic [3:0] MODE_THERMISTOR_ONLY_ALARM      = 4'h4;
	localparam logic [3:0] MODE_THERMISTOR_ONLY_WARNING    = 4'h5;
	localparam logic [3:0] MODE_COMBINED_ALARM             = 4'h6;
	localparam logic [3:0] MODE_COMBINED_WARNING           = 4'h7;
	localparam logic [3:0] MODE_COMBINED_ALARM_WARNING     = 4'h8;
	localparam logic [3:0] MODE_COMBINED_WARNING_ALARM     = 4'h9;
	localparam logic [3:0] MODE_RESET                      = 4'h1;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CONTROL_RESET_BIT = 0;
	localparam int EVT_ACTIVATED_BIT = 0;
	localparam int EVT_DANGER_BIT    = 1;
	localparam int EVT_RESUMED_BIT   = 2;
	localparam int EVT_WIDTH         = 3;
	localparam logic [EVT_WIDTH-1:0] EVT_RESET = 3'h0;

	// ----------------------------------------
	// Timing: stop response bound (ns) and cycles at 100 MHz
	// ----------------------------------------
	localparam longint STO_RESPONSE_NS  = 10000000;
	localparam longint CLOCK_PERIOD_NS  = 10;
	localparam longint STO_RESPONSE_CYC = STO_RESPONSE_NS / CLOCK_PERIOD_NS;

	// ----------------------------------------
	// Supervisor states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_RUN        = 2'b00,
		ST_OFF_LOW    = 2'b01,
		ST_OFF_WAIT   = 2'b10,
		ST_DANGER     = 2'b11
	} sto_state_t;

endpackage : sto_pkg

// *** verification/sto_supervisor_asserts.sv ***
`timescale 1ns/1ps
module sto_supervisor_asserts (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// Safety pins
	input wire logic        safety_disable_input,
	input wire logic        field_enable,
	input wire logic        brake_engage,
	input wire logic        torque_off_status,
	input wire logic        torque_off_alarm_code,
	input wire logic        torque_off_warning_code,
	input wire logic        dangerous_failure_alarm_code,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Stop request held through the synchroniser
	sequence stop_held;
		!safety_disable_input [*3];
	endsequence
	// Address and data taken at one edge
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	stop_coast_a: assert property (stop_held |=> !field_enable)
		else $error("field still enabled after stop");
	fall_brake_a: assert property ($fell(field_enable) |-> ##[0:1] (brake_engage && torque_off_status))
		else $error("brake or status missing at stop");
	restart_cause_a: assert property ($rose(field_enable) |-> $past(safety_disable_input, 2))
		else $error("field resumed without safety input");
	status_clear_a: assert property ($fell(torque_off_status) |-> ##[0:1] field_enable)
		else $error("status cleared before running");
	run_clean_a: assert property (field_enable && $past(field_enable) |->
		!(torque_off_status || brake_engage || torque_off_alarm_code || dangerous_failure_alarm_code))
		else $error("indication left while running");
	code_excl_a: assert property (!(torque_off_alarm_code && torque_off_warning_code))
		else $error("alarm and warning together");
	danger_hold_a: assert property (dangerous_failure_alarm_code |-> !field_enable && brake_engage)
		else $error("field on with dangerous failure");
	write_answer_a: assert property (wr_take && !s_axi_bvalid |=> ##1 s_axi_bvalid)
		else $error("write response late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
endmodule : sto_supervisor_asserts

bind sto_supervisor sto_supervisor_asserts u_asserts (.clock, .rst_n, .safety_disable_input, .field_enable,
	.brake_engage, .torque_off_status, .torque_off_alarm_code, .torque_off_warning_code,
	.dangerous_failure_alarm_code, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// *** verification/safety_relay_model.sv ***
`timescale 1ns/1ps
module safety_relay_model (
	// Clock
	input wire logic clock,
	// Sensor chain and thermistor module
	input wire logic sensor_ok,
	input wire logic thermistor_trip_output,
	// Contact to the drive
	output logic     safety_disable_input
);
	// Contact closes only while both chains are healthy
	initial safety_disable_input = 1'h0;
	always @(posedge clock) begin
		safety_disable_input <= sensor_ok && thermistor_trip_output;
	end
endmodule : safety_relay_model

// *** verification/safe_torque_off_restart_control_tb_top.sv ***
`timescale 1ns/1ps
module safe_torque_off_restart_control_tb_top;
	import sto_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clock, rst_n, sensor_ok, thermistor_trip_output, thermistor_present, digital_reset_input;
	logic        local_operator_panel_reset, safety_disable_input, field_enable, brake_engage, irq;
	logic        torque_off_status, torque_off_alarm_code, torque_off_warning_code, dangerous_failure_alarm_code;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, auto_on, rd_alt;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, lfsr_q;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [33:0] exp_q[$], mask_q[$], mon_mask;
	logic [3:0]  modes [6] = '{4'h1, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9};
	int          err_count, comparisons;
	localparam logic [33:0] FULL = 34'h3FFFFFFFF;
	localparam logic [33:0] NOCODE = 34'h3FFFFFFF3;

	sto_supervisor dut (.clock, .rst_n, .safety_disable_input, .thermistor_trip_output, .thermistor_present,
		.digital_reset_input, .local_operator_panel_reset, .field_enable, .brake_engage, .torque_off_status,
		.torque_off_alarm_code, .torque_off_warning_code, .dangerous_failure_alarm_code, .irq,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	safety_relay_model relay (.clock, .sensor_ok, .thermistor_trip_output, .safety_disable_input);

	// 100 MHz clock
	always #5 clock = ~clock;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	function automatic logic [33:0] st(input logic [1:0] s, input logic a68, w68, a72, sf, tr);
		return {26'h0, thermistor_present, tr, sf, a72, w68, a68, s};
	endfunction : st

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One bus access; every answer leaves its expectation in the queue
	// Every second read raises rready only after rvalid shows
	task automatic xfer(input logic w, input logic [7:0] a, input logic [33:0] d, input logic [33:0] m);
		logic p0, p1, done, rv, late;
		p0 = 1'h1;
		p1 = w;
		done = 1'h0;
		rv = 1'h0;
		late = !w && rd_alt;
		if (!w) begin
			rd_alt = !rd_alt;
			exp_q.push_back(d);
			mask_q.push_back(m);
		end else begin
			exp_q.push_back({(a inside {MODE_OFS, STATUS_OFS, CONTROL_OFS, IRQ_STATUS_OFS, IRQ_CLEAR_OFS,
				IRQ_ENABLE_OFS}) ? 2'h0 : 2'h2, 32'h0});
			mask_q.push_back(34'h300000000);
		end
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d[31:0];
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w && !late;
		while (!done) begin
			@(negedge clock);
			p0 = p0 && !(w ? s_axi_awready : s_axi_arready);
			p1 = p1 && !s_axi_wready;
			rv = s_axi_rvalid;
			done = w ? s_axi_bvalid : (s_axi_rvalid && s_axi_rready);
			@(posedge clock);
			if (w) begin
				s_axi_awvalid <= p0;
				s_axi_wvalid <= p1;
				if (done) begin
					s_axi_bready <= 1'h0;
				end
			end else begin
				s_axi_arvalid <= p0;
				s_axi_rready <= !done && (s_axi_rready || rv);
			end
		end
	endtask : xfer

	// Reset request from input, key or bus
	task automatic pulse(input int k);
		if (k == 2) xfer(1'h1, CONTROL_OFS, 34'h1, '0);
		@(posedge clock);
		digital_reset_input <= (k == 0);
		local_operator_panel_reset <= (k == 1);
		repeat (4) @(posedge clock);
		digital_reset_input <= 1'h0;
		local_operator_panel_reset <= 1'h0;
		repeat (4) @(posedge clock);
	endtask : pulse

	task automatic settle();
		repeat (6) @(posedge clock);
		@(negedge clock);
	endtask : settle

	task automatic finish_test();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	// Read and write answers against the oldest note
	always @(negedge clock) begin
		if (((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) && exp_q.size() > 0) begin
			mon_mask = mask_q.pop_front();
			check((s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}) & mon_mask,
				exp_q.pop_front() & mon_mask);
		end
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		finish_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{clock, rst_n, thermistor_present, digital_reset_input, local_operator_panel_reset, rd_alt} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{sensor_ok, thermistor_trip_output, s_axi_wstrb} = 6'h3F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		lfsr_q = 32'h2A4DB297;
		err_count = 0;
		comparisons = 0;
		repeat (4) @(posedge clock);
		rst_n <= 1'h1;
		settle();
		xfer(1'h0, MODE_OFS, {30'h0, MODE_RESET}, FULL);
		xfer(1'h0, STATUS_OFS, st(2'h2, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0), FULL);
		// Extended codes refused without the module
		xfer(1'h1, MODE_OFS, 34'h7, '0);
		xfer(1'h0, MODE_OFS, 34'h1, FULL);
		thermistor_present <= 1'h1;
		pulse(0);
		xfer(1'h0, STATUS_OFS, st(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0), FULL);
		// Stop and restart in each combined or standalone mode
		for (int i = 0; i < 6; i++) begin
			auto_on = modes[i] inside {4'h3, 4'h7, 4'h8};
			lfsr_q = lfsr_next(lfsr_q);
			xfer(1'h1, MODE_OFS, {2'h0, lfsr_q[31:4], modes[i]}, '0);
			xfer(1'h0, MODE_OFS, {30'h0, modes[i]}, FULL);
			@(posedge clock);
			sensor_ok <= 1'h0;
			settle();
			check({28'h0, field_enable, brake_engage, torque_off_status, torque_off_alarm_code,
				torque_off_warning_code, dangerous_failure_alarm_code},
				{28'h0, 1'h0, 1'h1, 1'h1, !auto_on, auto_on, 1'h0});
			xfer(1'h0, STATUS_OFS, st(2'h1, !auto_on, auto_on, 1'h0, 1'h0, 1'h0), FULL);
			pulse(int'(lfsr_q[1:0]) % 3);
			xfer(1'h0, STATUS_OFS, st(2'h1, !auto_on, auto_on, 1'h0, 1'h0, 1'h0), FULL);
			@(posedge clock);
			sensor_ok <= 1'h1;
			settle();
			check({33'h0, field_enable}, {33'h0, auto_on});
			if (auto_on) begin
				xfer(1'h0, STATUS_OFS, st(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0), FULL);
			end else begin
				xfer(1'h0, STATUS_OFS, st(2'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0), FULL);
				pulse(i % 3);
				xfer(1'h0, STATUS_OFS, st(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0), FULL);
			end
		end
		// Thermistor trip in a standalone mode
		xfer(1'h1, MODE_OFS, 34'h1, '0);
		@(posedge clock);
		thermistor_trip_output <= 1'h0;
		settle();
		xfer(1'h0, STATUS_OFS, st(2'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1), NOCODE);
		check({31'h0, field_enable, brake_engage, dangerous_failure_alarm_code}, 34'h3);
		@(posedge clock);
		thermistor_trip_output <= 1'h1;
		settle();
		xfer(1'h0, STATUS_OFS, st(2'h3, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0), NOCODE);
		pulse(2);
		xfer(1'h0, STATUS_OFS, st(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0), FULL);
		// External stop in a thermistor-only mode
		xfer(1'h1, MODE_OFS, 34'h4, '0);
		@(posedge clock);
		sensor_ok <= 1'h0;
		settle();
		xfer(1'h0, STATUS_OFS, st(2'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0), NOCODE);
		check({31'h0, field_enable, brake_engage, dangerous_failure_alarm_code}, 34'h3);
		@(posedge clock);
		sensor_ok <= 1'h1;
		settle();
		pulse(1);
		xfer(1'h0, STATUS_OFS, st(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0), FULL);
		// Interrupt mask, raise and clear
		xfer(1'h1, IRQ_ENABLE_OFS, 34'h0, '0);
		@(negedge clock);
		check({33'h0, irq}, 34'h0);
		xfer(1'h0, IRQ_STATUS_OFS, 34'h7, FULL);
		xfer(1'h1, IRQ_ENABLE_OFS, 34'h2, '0);
		@(negedge clock);
		check({33'h0, irq}, 34'h1);
		xfer(1'h1, IRQ_CLEAR_OFS, 34'h2, '0);
		@(negedge clock);
		check({33'h0, irq}, 34'h0);
		xfer(1'h0, IRQ_STATUS_OFS, 34'h5, FULL);
		xfer(1'h0, IRQ_CLEAR_OFS, 34'h0, FULL);
		xfer(1'h0, 8'h40, {2'h2, 32'h0}, FULL);
		// Write to an unmapped word answers with an error
		xfer(1'h1, 8'h40, 34'h0, '0);
		repeat (4) @(posedge clock);
		finish_test();
	end
endmodule : safe_torque_off_restart_control_tb_top
